/* File: tswc_config_regs.sv */
// Stop-window configuration registers with APB access, timeout, result and interrupts.
//
// How it works
// - Register 2 bits 31, 30 and 29 enable the timeout, end-of-hits and ALU interrupts, only ALU after reset.
// - The enabled interrupt sources are ORed onto the one interrupt output.
// - Bits 28 and 27 make stop channels 2 and 1 count both edges when set, one edge when clear.
// - Register 2 bits 26 to 8 hold the 14.5 fixed-point stop-enable delay for hit 1 of channel 1.
// - The low eight bits of registers 2 and 3 are free tag storage with no effect on measurement.
// - With register 3 bit 31 set in mode 2 the results of all hits are summed into the result register.
// - Register 3 bit 30 turns on first-hit detection and switches the delay field to period counts.
// - With register 3 bit 29 set a timeout writes 'hFFFFFFF into the result register.
// - Register 3 bits 28 to 27 pick a mode-2 timeout of 64, 256, 1024 or 4096 us, resetting to 3.
// - Without first-hit detection register 3 bits 26 to 8 hold a start-based 14.5 stop-enable delay.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`include "tswc_defines.svh"
module tswc_config_regs #(
    parameter int HS_DIV = `TSWC_HS_DIV
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic meas_start_i,
    input wire logic meas_mode2_i,
    input wire logic alu_result_valid_i,
    input wire logic [31:0] alu_result_i,
    input wire logic end_hits_i,
    input wire logic meas_done_i,
    output tswc_pkg::tswc_active_cfg_type active_cfg_o,
    output logic busy_o,
    output logic irq_o
);
    import tswc_pkg::*;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    tswc_reg2_type reg2_q;
    tswc_reg3_type reg3_q;
    tswc_active_cfg_type cfg_q;
    tswc_state_type state_q;
    logic [31:0] result_q;
    logic [31:0] sum_q;
    logic [31:0] sum_d;
    logic timeout_evt;
    logic run_end;
    tswc_events_type evt_set;
    tswc_events_type evt_clr;
    tswc_events_type evt_en;
    tswc_events_type status;
    logic setup_phase;
    logic access_wr;
    logic [7:0] idx;
    logic aligned;
    logic [1:0] dec;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] wdata,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [1:0] decode(input logic [7:0] index, input logic ok, input logic wr);
        // Bit 1 flags a permitted access (aligned, mapped, not a write to the result or status register), bit 0 flags a write to a writable register.
        if (!ok) begin
            decode = 2'b00;
        end else if (index == `TSWC_REG2_IDX || index == `TSWC_REG3_IDX) begin
            decode = {1'b1, wr};
        end else if (index == `TSWC_CLEAR_IDX) begin
            decode = {1'b1, wr};
        end else if (index == `TSWC_RESULT_IDX || index == `TSWC_STATUS_IDX) begin
            decode = {!wr, 1'b0};
        end else begin
            decode = 2'b00;
        end
    endfunction

    assign idx = paddr_i[9:2];
    assign aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[11:10] == 2'b00);
    assign setup_phase = psel_i && !penable_i;
    assign dec = decode(idx, aligned, pwrite_i);
    assign access_wr = psel_i && penable_i && pready_o && pwrite_i && dec[0];

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Every transfer takes exactly one access cycle, so pready is raised by the setup phase.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= setup_phase;
            pslverr_o <= setup_phase && !dec[1];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            prdata_o <= '0;
        end else if (setup_phase && !pwrite_i) begin
            if (!aligned) begin
                prdata_o <= '0;
            end else if (idx == `TSWC_REG2_IDX) begin
                prdata_o <= reg2_q;
            end else if (idx == `TSWC_REG3_IDX) begin
                prdata_o <= reg3_q;
            end else if (idx == `TSWC_RESULT_IDX) begin
                prdata_o <= result_q;
            end else if (idx == `TSWC_STATUS_IDX) begin
                prdata_o <= {status, 28'h0000000, state_q == TSWC_RUN};
            end else begin
                prdata_o <= '0;
            end
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            reg2_q <= `TSWC_REG2_RST;
        end else if (access_wr && idx == `TSWC_REG2_IDX) begin
            reg2_q <= merge_lanes(reg2_q, pwdata_i, pstrb_i);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            reg3_q <= `TSWC_REG3_RST;
        end else if (access_wr && idx == `TSWC_REG3_IDX) begin
            reg3_q <= merge_lanes(reg3_q, pwdata_i, pstrb_i);
        end
    end

    // ----------------------------------------
    // Settings taken at measurement start
    // ----------------------------------------
    // Snapshotting keeps a running measurement consistent while software rewrites the registers.
    // The tag bytes are never copied, so they cannot disturb a measurement.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cfg_q <= '0;
            cfg_q.long_range_timeout_sel <= reg3_q.long_range_timeout_sel;
        end else if (meas_start_i && state_q == TSWC_IDLE) begin
            cfg_q.chan_two_both_edges <= reg2_q.chan_two_both_edges;
            cfg_q.chan_one_both_edges <= reg2_q.chan_one_both_edges;
            cfg_q.hit_one_stop_delay <= reg2_q.hit_one_stop_delay;
            cfg_q.auto_sum_long_range <= reg3_q.auto_sum_long_range;
            cfg_q.first_wave_en <= reg3_q.first_wave_en;
            cfg_q.timeout_error_fill <= reg3_q.timeout_error_fill;
            cfg_q.long_range_timeout_sel <= reg3_q.long_range_timeout_sel;
            cfg_q.mode2 <= meas_mode2_i;
            if (reg3_q.first_wave_en) begin
                cfg_q.start_based_stop_delay <= '0;
                cfg_q.stop_one_period_count <= reg3_q.delay_field[5:0];
                cfg_q.stop_two_period_count <= reg3_q.delay_field[11:6];
                cfg_q.stop_three_period_count <= reg3_q.delay_field[17:12];
            end else begin
                cfg_q.start_based_stop_delay <= reg3_q.delay_field;
                cfg_q.stop_one_period_count <= '0;
                cfg_q.stop_two_period_count <= '0;
                cfg_q.stop_three_period_count <= '0;
            end
        end
    end

    assign active_cfg_o = cfg_q;

    // ----------------------------------------
    // Measurement state
    // ----------------------------------------
    assign run_end = meas_done_i || timeout_evt;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= TSWC_IDLE;
        end else begin
            case (state_q)
                TSWC_IDLE: begin
                    if (meas_start_i) begin
                        state_q <= TSWC_RUN;
                    end
                end
                TSWC_RUN: begin
                    if (run_end) begin
                        state_q <= TSWC_IDLE;
                    end
                end
                default: begin
                    state_q <= TSWC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_q == TSWC_IDLE) ? meas_start_i : !run_end;
        end
    end

    tswc_timeout #(
        .HS_DIV(HS_DIV)
    ) u_timeout (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .run_i(state_q == TSWC_RUN && cfg_q.mode2),
        .sel_i(cfg_q.long_range_timeout_sel),
        .expired_o(timeout_evt)
    );

    // ----------------------------------------
    // Result register
    // ----------------------------------------
    always_comb begin
        sum_d = sum_q;
        if (alu_result_valid_i) begin
            sum_d = sum_q + alu_result_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || state_q == TSWC_IDLE) begin
            sum_q <= '0;
        end else begin
            sum_q <= sum_d;
        end
    end

    // A timeout with error fill enabled overrides a completion in the same cycle, since the sum is then incomplete.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            result_q <= '0;
        end else if (state_q == TSWC_RUN) begin
            if (timeout_evt && cfg_q.timeout_error_fill) begin
                result_q <= `TSWC_ERR_VALUE;
            end else if (cfg_q.auto_sum_long_range && cfg_q.mode2) begin
                if (meas_done_i) begin
                    result_q <= sum_d;
                end
            end else if (alu_result_valid_i) begin
                result_q <= alu_result_i;
            end
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    assign evt_set.timeout = timeout_evt;
    assign evt_set.end_hits = end_hits_i && state_q == TSWC_RUN;
    assign evt_set.alu = meas_done_i && state_q == TSWC_RUN && !timeout_evt;
    assign evt_clr = access_wr && idx == `TSWC_CLEAR_IDX ? pwdata_i[`TSWC_IRQ_MSB:`TSWC_IRQ_LSB] : 3'h0;
    assign evt_en = {reg2_q.en_timeout, reg2_q.en_end_hits, reg2_q.en_alu};

    tswc_irq_ctrl u_irq (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .set_i(evt_set),
        .clr_i(evt_clr),
        .en_i(evt_en),
        .status_o(status),
        .irq_o(irq_o)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    property p_reset_irq_en;
        $fell(sys_rst_i) |-> evt_en == `TSWC_IRQ_EN_RST;
    endproperty
    a_reset_irq_en: assert property (p_reset_irq_en) else $error("wrong interrupt enables after reset");

    property p_edge_apply;
        meas_start_i && state_q == TSWC_IDLE |=>
            {cfg_q.chan_two_both_edges, cfg_q.chan_one_both_edges} == $past(reg2_q[28:27]);
    endproperty
    a_edge_apply: assert property (p_edge_apply) else $error("edge mode not applied");

    property p_delay_one_apply;
        meas_start_i && state_q == TSWC_IDLE |=> cfg_q.hit_one_stop_delay == $past(reg2_q[26:8]);
    endproperty
    a_delay_one_apply: assert property (p_delay_one_apply) else $error("hit one delay not applied");

    property p_tag_store;
        access_wr && idx == `TSWC_REG3_IDX && pstrb_i[0] |=> reg3_q.user_tag_three == $past(pwdata_i[7:0]);
    endproperty
    a_tag_store: assert property (p_tag_store) else $error("tag byte not stored");

    property p_auto_sum;
        state_q == TSWC_RUN && meas_done_i && !timeout_evt && cfg_q.auto_sum_long_range && cfg_q.mode2
            |=> result_q == $past(sum_d);
    endproperty
    a_auto_sum: assert property (p_auto_sum) else $error("sum not written");

    property p_first_wave;
        meas_start_i && state_q == TSWC_IDLE && reg3_q.first_wave_en |=>
            cfg_q.stop_two_period_count == $past(reg3_q[19:14]) && cfg_q.start_based_stop_delay == 19'h0;
    endproperty
    a_first_wave: assert property (p_first_wave) else $error("first wave layout not used");

    property p_err_fill;
        state_q == TSWC_RUN && timeout_evt && cfg_q.timeout_error_fill |=> result_q == `TSWC_ERR_VALUE ##1 !busy_o;
    endproperty
    a_err_fill: assert property (p_err_fill) else $error("error value not written");

    property p_start_delay;
        meas_start_i && state_q == TSWC_IDLE && !reg3_q.first_wave_en |=>
            cfg_q.start_based_stop_delay == $past(reg3_q[26:8]);
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("start delay not applied");

    property p_hold_cfg;
        !(meas_start_i && state_q == TSWC_IDLE) |=> $stable(cfg_q);
    endproperty
    a_hold_cfg: assert property (p_hold_cfg) else $error("settings changed outside a start");

    c_timeout: cover property (state_q == TSWC_RUN && timeout_evt);
    c_auto_sum: cover property (state_q == TSWC_RUN && meas_done_i && cfg_q.auto_sum_long_range);
    c_first_wave: cover property (meas_start_i && reg3_q.first_wave_en);
    c_irq: cover property ($rose(irq_o));

endmodule

/* File: tswc_defines.svh */
// Offsets, field positions, reset values and timing counts of the stop-window configuration block.
`ifndef TSWC_DEFINES_SVH
`define TSWC_DEFINES_SVH

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define TSWC_REG2_IDX 8'h02
`define TSWC_REG3_IDX 8'h03
`define TSWC_RESULT_IDX 8'h10
`define TSWC_STATUS_IDX 8'h11
`define TSWC_CLEAR_IDX 8'h12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TSWC_IRQ_MSB 31
`define TSWC_IRQ_LSB 29
`define TSWC_EDGE_MSB 28
`define TSWC_EDGE_LSB 27
`define TSWC_DELAY_MSB 26
`define TSWC_DELAY_LSB 8
`define TSWC_TAG_MSB 7
`define TSWC_TAG_LSB 0
`define TSWC_STATUS_BUSY_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TSWC_REG2_RST 32'h2000_0000
`define TSWC_REG3_RST 32'h1800_0000
`define TSWC_IRQ_EN_RST 3'h1
`define TSWC_ERR_VALUE 32'h0fff_ffff

// ----------------------------------------
// Timing
// ----------------------------------------
`define TSWC_SYS_CLK_MHZ 100
`define TSWC_HS_CLK_MHZ 4
`define TSWC_HS_DIV (`TSWC_SYS_CLK_MHZ / `TSWC_HS_CLK_MHZ)
`define TSWC_TIMO0_US 64
`define TSWC_TIMO1_US 256
`define TSWC_TIMO2_US 1024
`define TSWC_TIMO3_US 4096
`define TSWC_US_TO_TICKS(us) ((us) * `TSWC_HS_CLK_MHZ)

`endif

/* File: tswc_pkg.sv */
// Types shared by the stop-window configuration block.
package tswc_pkg;

    // ----------------------------------------
    // Register layouts
    // ----------------------------------------
    typedef struct packed {
        logic en_timeout;
        logic en_end_hits;
        logic en_alu;
        logic chan_two_both_edges;
        logic chan_one_both_edges;
        logic [18:0] hit_one_stop_delay;
        logic [7:0] user_tag_two;
    } tswc_reg2_type;

    typedef struct packed {
        logic auto_sum_long_range;
        logic first_wave_en;
        logic timeout_error_fill;
        logic [1:0] long_range_timeout_sel;
        logic [18:0] delay_field;
        logic [7:0] user_tag_three;
    } tswc_reg3_type;

    // ----------------------------------------
    // Settings applied to the running measurement
    // ----------------------------------------
    typedef struct packed {
        logic chan_two_both_edges;
        logic chan_one_both_edges;
        logic [18:0] hit_one_stop_delay;
        logic auto_sum_long_range;
        logic first_wave_en;
        logic timeout_error_fill;
        logic [1:0] long_range_timeout_sel;
        logic [18:0] start_based_stop_delay;
        logic [5:0] stop_one_period_count;
        logic [5:0] stop_two_period_count;
        logic [5:0] stop_three_period_count;
        logic mode2;
    } tswc_active_cfg_type;

    typedef struct packed {
        logic timeout;
        logic end_hits;
        logic alu;
    } tswc_events_type;

    typedef enum logic [1:0] {
        TSWC_IDLE = 2'b00,
        TSWC_RUN = 2'b01
    } tswc_state_type;

endpackage

/* File: tswc_irq_ctrl.sv */
// Sticky interrupt status with enables and a single level output.
`timescale 1ns/100ps
module tswc_irq_ctrl (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire tswc_pkg::tswc_events_type set_i,
    input wire tswc_pkg::tswc_events_type clr_i,
    input wire tswc_pkg::tswc_events_type en_i,
    output tswc_pkg::tswc_events_type status_o,
    output logic irq_o
);
    import tswc_pkg::*;

    tswc_events_type status_q;

    // A set in the same cycle as its clear wins, so no event is lost.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~clr_i) | set_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_q & en_i);
        end
    end

    assign status_o = status_q;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    property p_irq_or;
        (|(status_q & en_i)) |=> irq_o;
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("enabled source did not raise irq");

    property p_irq_quiet;
        !(|(status_q & en_i)) |=> !irq_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq raised with no enabled source");

endmodule

/* File: tswc_timeout.sv */
// Mode-2 timeout counter driven by a high-speed tick divided from the system clock.
`timescale 1ns/100ps
`include "tswc_defines.svh"
module tswc_timeout #(
    parameter int HS_DIV = `TSWC_HS_DIV
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic run_i,
    input wire logic [1:0] sel_i,
    output logic expired_o
);
    import tswc_pkg::*;

    logic [5:0] div_q;
    logic hs_tick_q;
    logic [14:0] tick_q;

    function automatic logic [14:0] limit_of(input logic [1:0] sel);
        case (sel)
            2'd0: limit_of = 15'(`TSWC_US_TO_TICKS(`TSWC_TIMO0_US) - 1);
            2'd1: limit_of = 15'(`TSWC_US_TO_TICKS(`TSWC_TIMO1_US) - 1);
            2'd2: limit_of = 15'(`TSWC_US_TO_TICKS(`TSWC_TIMO2_US) - 1);
            default: limit_of = 15'(`TSWC_US_TO_TICKS(`TSWC_TIMO3_US) - 1);
        endcase
    endfunction

    // The divider restarts with each run so every timeout has the full length.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || !run_i) begin
            div_q <= '0;
            hs_tick_q <= 1'b0;
        end else begin
            hs_tick_q <= (div_q == 6'(HS_DIV - 1));
            div_q <= (div_q == 6'(HS_DIV - 1)) ? 6'h00 : div_q + 6'h01;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || !run_i) begin
            tick_q <= '0;
            expired_o <= 1'b0;
        end else begin
            expired_o <= 1'b0;
            if (hs_tick_q) begin
                tick_q <= tick_q + 15'h0001;
                expired_o <= (tick_q == limit_of(sel_i));
            end
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    property p_timeout_count;
        expired_o |-> $past(tick_q) == limit_of($past(sel_i));
    endproperty
    a_timeout_count: assert property (p_timeout_count) else $error("timeout at wrong count");

endmodule

/* File: tb_top.sv */
// Self-checking testbench of the stop-window configuration registers.
`timescale 1ns/100ps
`include "tswc_defines.svh"
module tb_top;
    import tswc_pkg::*;
    // ----------------------------------------
    // Signals and design
    // ----------------------------------------
    localparam logic [11:0] A_REG2 = {2'b00, `TSWC_REG2_IDX, 2'b00};
    localparam logic [11:0] A_REG3 = {2'b00, `TSWC_REG3_IDX, 2'b00};
    localparam logic [11:0] A_RES = {2'b00, `TSWC_RESULT_IDX, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, `TSWC_STATUS_IDX, 2'b00};
    localparam logic [11:0] A_CLR = {2'b00, `TSWC_CLEAR_IDX, 2'b00};
    typedef struct {logic [11:0] a; logic [31:0] d; logic werr; logic [31:0] rexp; logic rerr;} tswc_row_type;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic meas_start_i = 1'b0;
    logic meas_mode2_i = 1'b0;
    logic alu_result_valid_i = 1'b0;
    logic [31:0] alu_result_i = 32'h0;
    logic end_hits_i = 1'b0;
    logic meas_done_i = 1'b0;
    tswc_active_cfg_type active_cfg_o;
    logic busy_o;
    logic irq_o;
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int checked = 0;
    tswc_row_type rows [9];

    // HS_DIV of 1 keeps the longest timeout near sixteen thousand cycles.
    tswc_config_regs #(.HS_DIV(1)) tswc_config_regs_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .meas_start_i(meas_start_i), .meas_mode2_i(meas_mode2_i), .alu_result_valid_i(alu_result_valid_i),
        .alu_result_i(alu_result_i), .end_hits_i(end_hits_i), .meas_done_i(meas_done_i),
        .active_cfg_o(active_cfg_o), .busy_o(busy_o), .irq_o(irq_o));

    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task test_done;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) begin
            num_errors++;
            test_done;
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task meas(input logic m);
        meas_start_i <= 1'b1;
        meas_mode2_i <= m;
        @(posedge clk_sys_i);
        meas_start_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task res(input logic [31:0] v, input logic eh, input logic dn);
        alu_result_valid_i <= 1'b1;
        alu_result_i <= v;
        end_hits_i <= eh;
        meas_done_i <= dn;
        @(posedge clk_sys_i);
        alu_result_valid_i <= 1'b0;
        end_hits_i <= 1'b0;
        meas_done_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    // A run that never ends would hang the bench, so the wait is capped.
    task idle(output int n);
        n = 0;
        while (busy_o !== 1'b0) begin
            @(posedge clk_sys_i);
            n++;
            if (n > 20000) begin
                num_errors++;
                test_done;
            end
        end
        repeat (2) @(posedge clk_sys_i);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        int n;
        logic [1:0] sel;
        rows = '{'{A_REG2, 32'hffff_ffff, 0, 32'hffff_ffff, 0}, '{A_REG3, 32'h5a5a_5a5a, 0, 32'h5a5a_5a5a, 0},
            '{A_REG2, 32'h0, 0, 32'h0, 0}, '{A_RES, 32'h1234_5678, 1, 32'h0, 0}, '{A_STAT, 32'hffff_ffff, 1, 32'h0, 0},
            '{A_CLR, 32'he000_0000, 0, 32'h0, 0}, '{12'h0f0, 32'h1111_1111, 1, 32'h0, 1},
            '{12'h009, 32'h1, 1, 32'h0, 1}, '{12'h808, 32'h1, 1, 32'h0, 1}};
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        chk({30'h0, active_cfg_o.long_range_timeout_sel}, 32'h3);
        apb(1'b0, A_REG2, 32'h0);
        chk(rd, `TSWC_REG2_RST);
        apb(1'b0, A_REG3, 32'h0);
        chk(rd, `TSWC_REG3_RST);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            chk({31'h0, er}, {31'h0, rows[i].werr});
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].rexp);
            chk({31'h0, er}, {31'h0, rows[i].rerr});
        end
        // Summed run; the mid-run write must not reach the running settings.
        apb(1'b1, A_REG2, 32'h2000_0000);
        apb(1'b1, A_REG3, 32'h8000_1234);
        meas(1'b1);
        apb(1'b1, A_REG3, 32'h0);
        chk({31'h0, active_cfg_o.auto_sum_long_range}, 32'h1);
        chk({13'h0, active_cfg_o.start_based_stop_delay}, 32'h12);
        res(32'h10, 1'b1, 1'b0);
        res(32'h20, 1'b0, 1'b0);
        res(32'h30, 1'b0, 1'b1);
        idle(n);
        chk({31'h0, irq_o}, 32'h1);
        apb(1'b0, A_RES, 32'h0);
        chk(rd, 32'h60);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd, 32'h6000_0000);
        apb(1'b1, A_CLR, 32'he000_0000);
        repeat (2) @(posedge clk_sys_i);
        chk({31'h0, irq_o}, 32'h0);
        // First-wave layout with every source masked.
        apb(1'b1, A_REG2, 32'h1fff_ff00);
        apb(1'b1, A_REG3, 32'h4051_0300);
        meas(1'b0);
        chk({13'h0, active_cfg_o.hit_one_stop_delay}, 32'h7ffff);
        chk({30'h0, active_cfg_o.chan_two_both_edges, active_cfg_o.chan_one_both_edges}, 32'h3);
        chk({13'h0, active_cfg_o.first_wave_en, active_cfg_o.stop_three_period_count,
            active_cfg_o.stop_two_period_count, active_cfg_o.stop_one_period_count}, 32'h45103);
        res(32'h1234, 1'b0, 1'b1);
        idle(n);
        chk({31'h0, irq_o}, 32'h0);
        apb(1'b0, A_RES, 32'h0);
        chk(rd, 32'h1234);
        apb(1'b1, A_REG2, 32'h2000_0000);
        repeat (2) @(posedge clk_sys_i);
        chk({31'h0, irq_o}, 32'h1);
        apb(1'b1, A_CLR, 32'he000_0000);
        // Every timeout choice, with the error value filled in.
        apb(1'b1, A_REG2, 32'h8000_0000);
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            apb(1'b1, A_REG3, {3'b001, sel, 27'h0});
            meas(1'b1);
            chk({28'h0, active_cfg_o.timeout_error_fill, active_cfg_o.mode2, active_cfg_o.long_range_timeout_sel},
                {28'h0, 2'b11, sel});
            idle(n);
            chk({31'h0, (n >= (256 << (2 * s))) && (n <= (256 << (2 * s)) + 8)}, 32'h1);
            chk({31'h0, irq_o}, 32'h1);
            apb(1'b0, A_RES, 32'h0);
            chk(rd, `TSWC_ERR_VALUE);
            apb(1'b0, A_STAT, 32'h0);
            chk(rd, 32'h8000_0000);
            apb(1'b1, A_CLR, 32'he000_0000);
        end
        // A reset in the middle of a run must drop the run, clear the interrupt and restore register 2 and the timeout select.
        meas(1'b1);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        chk({31'h0, busy_o}, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        chk({30'h0, active_cfg_o.long_range_timeout_sel}, 32'h3);
        apb(1'b0, A_REG2, 32'h0);
        chk(rd, `TSWC_REG2_RST);
        test_done;
    end
endmodule
